// File: drive_operation_mode_selector.sv
// drive operation mode selector with an axi4-lite register slave
// assumes all inputs synchronous to aclk; key and request inputs are one-cycle pulses
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns

module drive_operation_mode_selector (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        forward_start_input,
  input  wire logic        reverse_start_input,
  input  wire logic        drive_stopped,
  input  wire logic        mode_lock_input,
  input  wire logic        panel_mode_key,
  input  wire logic        panel_network_toggle_input,
  input  wire logic        net_mode_req_valid,
  input  wire logic [1:0]  net_mode_req_target,
  input  wire logic        net_param_write_valid,
  input  wire logic        power_restored,
  input  wire logic        drive_reset_req,
  output logic [1:0]       op_mode,
  output logic             mode_req_refused,
  output logic             start_cmd_clear,
  output logic             resume_operation,
  output logic             param_write_ack,
  output logic             param_write_nack
);

  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  aw_have;
    logic                  w_have;
    logic [7:0]            waddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
    logic [3:0]            startup;
    logic [2:0]            mode_sel;
    logic [13:0]           coast;
    logic [3:0]            latched;
    logic                  powered;
    op_mode_pkg::op_mode_t mode;
    logic                  refused;
    logic                  refused_pulse;
    logic                  start_clear;
    logic                  resume;
    logic                  pw_ack;
    logic                  pw_nack;
    logic                  sw_req;
    op_mode_pkg::op_mode_t sw_target;
    logic                  toggle_q;
  } state_t;

  state_t                s_reg;
  state_t                s_next;
  logic                  quiet;
  logic                  latch_now;
  logic [3:0]            eff_setting;
  logic                  force_term;
  logic                  tog_rise;
  logic                  panel_req;
  logic                  req;
  logic                  take_sw;
  op_mode_pkg::op_mode_t req_target;
  op_mode_pkg::op_mode_t powerup;
  logic                  allowed;
  logic                  aw_hs;
  logic                  w_hs;
  logic                  ar_hs;
  logic                  do_wr;
  logic [7:0]            wr_addr;
  logic [31:0]           wr_data;
  logic [3:0]            wr_strb;
  logic                  direct_ok;

  assign quiet       = drive_stopped && !forward_start_input && !reverse_start_input;
  // the startup setting is only sampled here, so later writes wait for a reset
  assign latch_now   = !s_reg.powered || drive_reset_req;
  assign eff_setting = latch_now ? s_reg.startup : s_reg.latched;
  assign force_term  = (s_reg.mode_sel == op_mode_pkg::MS_7) && !mode_lock_input;
  assign tog_rise    = panel_network_toggle_input && !s_reg.toggle_q;
  assign panel_req   = panel_mode_key || tog_rise;
  assign direct_ok   = (s_reg.latched == op_mode_pkg::SU_10) ||
                       (s_reg.latched == op_mode_pkg::SU_12);

  // request priority: panel key/toggle, then network master, then software
  always_comb begin
    req        = 1'b1;
    take_sw    = 1'b0;
    req_target = op_mode_pkg::terminal_mode;
    if (panel_req) begin
      req_target = (s_reg.mode == op_mode_pkg::panel_mode) ? op_mode_pkg::network_mode
                                                           : op_mode_pkg::panel_mode;
    end else if (net_mode_req_valid) begin
      req_target = op_mode_pkg::op_mode_t'(net_mode_req_target);
    end else if (s_reg.sw_req) begin
      req_target = s_reg.sw_target;
      take_sw    = 1'b1;
    end else begin
      req = 1'b0;
    end
  end
  mode_policy policy (
    .startup_mode_setting (eff_setting),
    .mode_select_setting  (s_reg.mode_sel),
    .mode_lock_input      (mode_lock_input),
    .quiet                (quiet),
    .current              (s_reg.mode),
    .target               (req_target),
    .powerup              (powerup),
    .allowed              (allowed)
  );
  assign aw_hs   = awvalid && s_reg.awready;
  assign w_hs    = wvalid && s_reg.wready;
  assign ar_hs   = arvalid && s_reg.arready;
  assign do_wr   = (s_reg.aw_have || aw_hs) && (s_reg.w_have || w_hs);
  assign wr_addr = s_reg.aw_have ? s_reg.waddr : awaddr;
  assign wr_data = s_reg.w_have ? s_reg.wdata : wdata;
  assign wr_strb = s_reg.w_have ? s_reg.wstrb : wstrb;

  always_comb begin
    s_next               = s_reg;
    s_next.refused_pulse = 1'b0;
    s_next.resume        = 1'b0;
    s_next.pw_ack        = 1'b0;
    s_next.pw_nack       = 1'b0;
    s_next.toggle_q      = panel_network_toggle_input;
    // write channel: address and data may arrive in either order
    if (aw_hs) begin
      s_next.aw_have = 1'b1;
      s_next.waddr   = awaddr;
    end
    if (w_hs) begin
      s_next.w_have = 1'b1;
      s_next.wdata  = wdata;
      s_next.wstrb  = wstrb;
    end
    if (s_reg.bvalid && bready) s_next.bvalid = 1'b0;
    if (take_sw) s_next.sw_req = 1'b0;
    if (do_wr) begin
      s_next.aw_have = 1'b0;
      s_next.w_have  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = op_mode_pkg::RESP_OKAY;
      case (wr_addr)
        op_mode_pkg::STARTUP_OFF: begin
          // no mode check: writable from any operating mode
          if (wr_strb[0] && (wr_data[3:0] == op_mode_pkg::SU_0 ||
              wr_data[3:0] == op_mode_pkg::SU_1 || wr_data[3:0] == op_mode_pkg::SU_2 ||
              wr_data[3:0] == op_mode_pkg::SU_10 || wr_data[3:0] == op_mode_pkg::SU_12)) begin
            s_next.startup = wr_data[3:0];
          end
        end
        op_mode_pkg::MODE_SEL_OFF: begin
          if (wr_strb[0] && wr_data[2:0] != op_mode_pkg::MS_5) s_next.mode_sel = wr_data[2:0];
        end
        op_mode_pkg::COAST_OFF: begin
          if (wr_strb[0]) s_next.coast[7:0] = wr_data[7:0];
          if (wr_strb[1]) s_next.coast[13:8] = wr_data[13:8];
        end
        op_mode_pkg::MODE_REQ_OFF: begin
          if (wr_strb[0]) begin
            s_next.sw_req    = 1'b1;
            s_next.sw_target = op_mode_pkg::op_mode_t'(wr_data[1:0]);
          end
        end
        op_mode_pkg::STATUS_OFF: s_next.bresp = op_mode_pkg::RESP_OKAY;
        default: s_next.bresp = op_mode_pkg::RESP_SLVERR;
      endcase
    end
    s_next.awready = !s_next.aw_have && !s_next.bvalid;
    s_next.wready  = !s_next.w_have && !s_next.bvalid;
    // read channel
    if (s_reg.rvalid && rready) s_next.rvalid = 1'b0;
    if (ar_hs) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = '0;
      s_next.rresp  = op_mode_pkg::RESP_OKAY;
      case (araddr)
        op_mode_pkg::STARTUP_OFF:  s_next.rdata[3:0]  = s_reg.startup;
        op_mode_pkg::MODE_SEL_OFF: s_next.rdata[2:0]  = s_reg.mode_sel;
        op_mode_pkg::COAST_OFF:    s_next.rdata[13:0] = s_reg.coast;
        op_mode_pkg::MODE_REQ_OFF: s_next.rdata[1:0]  = s_reg.sw_target;
        op_mode_pkg::STATUS_OFF: begin
          s_next.rdata[op_mode_pkg::ST_MODE_LSB +: 2]  = s_reg.mode;
          s_next.rdata[op_mode_pkg::ST_LATCH_LSB +: 4] = s_reg.latched;
          s_next.rdata[op_mode_pkg::ST_REFUSED_BIT]    = s_reg.refused;
          s_next.rdata[op_mode_pkg::ST_CLEAR_BIT]      = s_reg.start_clear;
          s_next.rdata[op_mode_pkg::ST_PWEN_BIT] = (s_reg.mode == op_mode_pkg::network_mode);
          s_next.rdata[op_mode_pkg::ST_PEND_BIT]       = s_reg.sw_req;
        end
        default: s_next.rresp = op_mode_pkg::RESP_SLVERR;
      endcase
    end
    s_next.arready = !s_next.rvalid;
    // operating mode; requests arriving with a reset or restoration are dropped
    if (latch_now) begin
      s_next.latched = s_reg.startup;
      s_next.powered = 1'b1;
      s_next.mode    = powerup;
    end else if (power_restored) begin
      s_next.mode = powerup;
    end else if (force_term) begin
      s_next.mode = op_mode_pkg::terminal_mode;
      if (req) begin
        s_next.refused       = 1'b1;
        s_next.refused_pulse = 1'b1;
      end
    end else if (req) begin
      if (allowed) begin
        s_next.mode    = req_target;
        s_next.refused = 1'b0;
      end else begin
        s_next.refused       = 1'b1;
        s_next.refused_pulse = 1'b1;
      end
    end
    // start command clearing: a fresh restoration wins over release of the starts
    if (!forward_start_input && !reverse_start_input) s_next.start_clear = 1'b0;
    if (s_reg.powered && power_restored &&
        (s_reg.latched == op_mode_pkg::SU_1 || s_reg.latched == op_mode_pkg::SU_10) &&
        (forward_start_input || reverse_start_input)) begin
      s_next.start_clear = 1'b1;
    end
    if (s_reg.powered && power_restored && s_reg.coast != op_mode_pkg::COAST_NO_RESTART) begin
      s_next.resume = 1'b1;
    end
    if (net_param_write_valid) begin
      s_next.pw_ack  = (s_reg.mode == op_mode_pkg::network_mode);
      s_next.pw_nack = (s_reg.mode != op_mode_pkg::network_mode);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg          <= '0;
      s_reg.startup  <= op_mode_pkg::STARTUP_RST;
      s_reg.mode_sel <= op_mode_pkg::MODE_SEL_RST;
      s_reg.coast    <= op_mode_pkg::COAST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready          = s_reg.awready;
  assign wready           = s_reg.wready;
  assign bvalid           = s_reg.bvalid;
  assign bresp            = s_reg.bresp;
  assign arready          = s_reg.arready;
  assign rvalid           = s_reg.rvalid;
  assign rresp            = s_reg.rresp;
  assign rdata            = s_reg.rdata;
  assign op_mode          = s_reg.mode;
  assign mode_req_refused = s_reg.refused_pulse;
  assign start_cmd_clear  = s_reg.start_clear;
  assign resume_operation = s_reg.resume;
  assign param_write_ack  = s_reg.pw_ack;
  assign param_write_nack = s_reg.pw_nack;

  property p_quiet_change;
    @(posedge aclk) disable iff (!aresetn)
      ($past(s_reg.powered) && !$past(latch_now) && !$past(power_restored) &&
       !$past(force_term) && $past(s_reg.mode_sel) != op_mode_pkg::MS_6 &&
       s_reg.mode != $past(s_reg.mode)) |-> $past(quiet);
  endproperty
  a_quiet_change: assert property (p_quiet_change) else $error("changed while running");
  property p_latch_stable;
    @(posedge aclk) disable iff (!aresetn)
      (s_reg.powered && !drive_reset_req) |=> $stable(s_reg.latched);
  endproperty
  a_latch_stable: assert property (p_latch_stable) else $error("applied without reset");
  property p_no_direct;
    @(posedge aclk) disable iff (!aresetn)
      ($past(s_reg.powered) && !$past(latch_now) && !$past(power_restored) &&
       (($past(s_reg.mode) == op_mode_pkg::panel_mode &&
         s_reg.mode == op_mode_pkg::network_mode) ||
        ($past(s_reg.mode) == op_mode_pkg::network_mode &&
         s_reg.mode == op_mode_pkg::panel_mode))) |-> $past(direct_ok);
  endproperty
  a_no_direct: assert property (p_no_direct) else $error("direct panel/network change");
  property p_panel_fixed;
    @(posedge aclk) disable iff (!aresetn)
      (s_reg.mode_sel == op_mode_pkg::MS_1 && s_reg.mode == op_mode_pkg::panel_mode)
        |=> s_reg.mode == op_mode_pkg::panel_mode;
  endproperty
  a_panel_fixed: assert property (p_panel_fixed) else $error("left fixed panel mode");
  property p_combined_fixed;
    @(posedge aclk) disable iff (!aresetn)
      ((s_reg.mode_sel == op_mode_pkg::MS_3 || s_reg.mode_sel == op_mode_pkg::MS_4) &&
       s_reg.mode == op_mode_pkg::combined_mode) |=> s_reg.mode == op_mode_pkg::combined_mode;
  endproperty
  a_combined_fixed: assert property (p_combined_fixed) else $error("left combined mode");
  property p_lock_force;
    @(posedge aclk) disable iff (!aresetn)
      (s_reg.powered && !drive_reset_req && force_term)
        |=> s_reg.mode == op_mode_pkg::terminal_mode;
  endproperty
  a_lock_force: assert property (p_lock_force) else $error("terminal not forced");
  property p_net_fixed;
    @(posedge aclk) disable iff (!aresetn)
      (direct_ok && !latch_now && s_reg.mode_sel == op_mode_pkg::MS_2 &&
       s_reg.mode == op_mode_pkg::network_mode) |=> s_reg.mode == op_mode_pkg::network_mode;
  endproperty
  a_net_fixed: assert property (p_net_fixed) else $error("left fixed network mode");
  property p_start_clear;
    @(posedge aclk) disable iff (!aresetn)
      (s_reg.powered && power_restored &&
       (s_reg.latched == op_mode_pkg::SU_1 || s_reg.latched == op_mode_pkg::SU_10) &&
       (forward_start_input || reverse_start_input)) |=> start_cmd_clear;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start command not cleared");
  property p_resume;
    @(posedge aclk) disable iff (!aresetn)
      (s_reg.powered && power_restored && s_reg.coast != op_mode_pkg::COAST_NO_RESTART)
        |=> resume_operation;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after restoration");
  property p_param_write;
    @(posedge aclk) disable iff (!aresetn)
      (net_param_write_valid && s_reg.mode == op_mode_pkg::network_mode)
        |=> (param_write_ack && !param_write_nack);
  endproperty
  a_param_write: assert property (p_param_write) else $error("parameter write refused");

endmodule // drive_operation_mode_selector

// File: drive_operation_mode_selector_tb.sv
// self-checking bench for the drive operation mode selector
// assumes the far side is far_side_model and registers sit on axi4-lite
`timescale 1ns/1ns
module drive_operation_mode_selector_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, refd, sclr, resm, pack, pnak;
  logic fwd, rev, stp, lck, key, tgl, nrv, npw, prs, drr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, ntg, op_mode;
  int failures, compares;
  drive_operation_mode_selector dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .forward_start_input(fwd),
    .reverse_start_input(rev), .drive_stopped(stp), .mode_lock_input(lck),
    .panel_mode_key(key), .panel_network_toggle_input(tgl), .net_mode_req_valid(nrv),
    .net_mode_req_target(ntg), .net_param_write_valid(npw), .power_restored(prs),
    .drive_reset_req(drr), .op_mode, .mode_req_refused(refd), .start_cmd_clear(sclr),
    .resume_operation(resm), .param_write_ack(pack), .param_write_nack(pnak));
  far_side_model far (.aclk, .forward_start_input(fwd), .reverse_start_input(rev),
    .drive_stopped(stp), .mode_lock_input(lck), .panel_mode_key(key),
    .panel_network_toggle_input(tgl), .net_mode_req_valid(nrv), .net_mode_req_target(ntg),
    .net_param_write_valid(npw), .power_restored(prs), .drive_reset_req(drr));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rb;
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'h7};
    for (int n = 0; n < 40; n++) begin
      #1;
      {ta, tw, tb, rb} = {awvalid & awready, wvalid & wready, bvalid & bready, bresp};
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        chk(rb, er);
        return;
      end
    end
    failures++;
    end_of_test();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (int n = 0; n < 40; n++) begin
      #1;
      {ta, tr} = {arvalid & arready, rvalid & rready};
      if (tr) begin
        chk(rresp, er);
        if (er == 2'h0) chk(rdata, ed);
      end
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    failures++;
    end_of_test();
  endtask
  task automatic req(input int n, input logic [1:0] t, input logic [1:0] m, input logic rf);
    far.fire(n, t);
    chk(op_mode, m);
    chk(refd, rf);
  endtask
  task automatic cfg(input logic [3:0] su, input logic [2:0] ms, input logic [1:0] boot);
    wr(8'h00, su, 2'h0);
    wr(8'h04, ms, 2'h0);
    far.fire(5, 2'h0);
    chk(op_mode, boot);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    {failures, compares} = 0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
    chk(op_mode, 2'h0);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h08, 32'h270f, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    req(0, 2'h0, 2'h1, 1'b0);
    req(2, 2'h2, 2'h1, 1'b1);
    req(2, 2'h0, 2'h0, 1'b0);
    far.fire(3, 2'h0);
    chk(pnak, 1'b1);
    req(1, 2'h0, 2'h1, 1'b0);
    req(2, 2'h0, 2'h0, 1'b0);
    req(2, 2'h2, 2'h2, 1'b0);
    far.fire(3, 2'h0);
    chk(pack, 1'b1);
    // a pending software request for panel mode from network mode must be refused
    wr(8'h0c, 32'h1, 2'h0);
    rd(8'h10, 32'h502, 2'h0);
    rd(8'h0c, 32'h1, 2'h0);
    req(0, 2'h0, 2'h2, 1'b1);
    far.levels(1'b0, 1'b1, 1'b1, 1'b0);
    req(2, 2'h0, 2'h2, 1'b1);
    far.levels(1'b0, 1'b0, 1'b0, 1'b0);
    req(2, 2'h0, 2'h2, 1'b1);
    cfg(4'h0, 3'h1, 2'h1);
    req(2, 2'h0, 2'h1, 1'b1);
    // stopped, so only the select-2 panel ban can refuse the next key press
    far.levels(1'b0, 1'b0, 1'b1, 1'b0);
    cfg(4'h0, 3'h2, 2'h0);
    req(0, 2'h0, 2'h0, 1'b1);
    for (int s = 3; s < 5; s++) begin
      cfg(4'h0, s[2:0], 2'h3);
      req(0, 2'h0, 2'h3, 1'b1);
    end
    far.levels(1'b0, 1'b0, 1'b0, 1'b0);
    cfg(4'h0, 3'h6, 2'h0);
    req(0, 2'h0, 2'h1, 1'b0);
    cfg(4'h0, 3'h7, 2'h0);
    req(0, 2'h0, 2'h0, 1'b1);
    far.levels(1'b0, 1'b0, 1'b1, 1'b1);
    far.fire(5, 2'h0);
    req(0, 2'h0, 2'h1, 1'b0);
    wr(8'h00, 32'h1, 2'h0);
    #1;
    chk(op_mode, 2'h1);
    rd(8'h00, 32'h1, 2'h0);
    rd(8'h10, 32'h1, 2'h0);
    far.fire(5, 2'h0);
    chk(op_mode, 2'h2);
    cfg(4'ha, 3'h2, 2'h2);
    req(0, 2'h0, 2'h2, 1'b1);
    cfg(4'hc, 3'h6, 2'h2);
    far.levels(1'b1, 1'b0, 1'b0, 1'b1);
    req(0, 2'h0, 2'h1, 1'b0);
    cfg(4'ha, 3'h0, 2'h2);
    far.fire(4, 2'h0);
    chk({sclr, resm}, 2'h2);
    wr(8'h08, 32'h0, 2'h0);
    far.fire(4, 2'h0);
    chk(resm, 1'b1);
    end_of_test();
  end
endmodule // drive_operation_mode_selector_tb

// File: far_side_model.sv
// far-side model: operator panel, control terminals and network master
// every output changes just after a rising aclk edge; requests last one cycle
`timescale 1ns/1ns
module far_side_model (
  input  wire logic  aclk,
  output logic       forward_start_input,
  output logic       reverse_start_input,
  output logic       drive_stopped,
  output logic       mode_lock_input,
  output logic       panel_mode_key,
  output logic       panel_network_toggle_input,
  output logic       net_mode_req_valid,
  output logic [1:0] net_mode_req_target,
  output logic       net_param_write_valid,
  output logic       power_restored,
  output logic       drive_reset_req
);
  logic [5:0] ev;
  assign {drive_reset_req, power_restored, net_param_write_valid, net_mode_req_valid,
          panel_network_toggle_input, panel_mode_key} = ev;
  initial begin
    ev = 6'h00;
    net_mode_req_target = 2'h0;
    {forward_start_input, reverse_start_input, mode_lock_input} = 3'h0;
    drive_stopped = 1'b1;
  end
  task automatic levels(input logic f, input logic r, input logic s, input logic l);
    @(posedge aclk);
    {forward_start_input, reverse_start_input, drive_stopped} <= {f, r, s};
    mode_lock_input <= l;
  endtask
  // n: 0 key, 1 toggle, 2 network request, 3 param write, 4 restore, 5 drive reset
  task automatic fire(input int n, input logic [1:0] t);
    @(posedge aclk);
    ev <= 6'h01 << n;
    net_mode_req_target <= t;
    @(posedge aclk);
    ev <= 6'h00;
    // a released target does not keep its last value
    net_mode_req_target <= ~t;
    #1;
  endtask
endmodule // far_side_model

// File: mode_policy.sv
// mode policy: power-up mode and permission for one mode change request
// purely combinational; the caller registers whatever it decides
`timescale 1ns/1ns
module mode_policy (
  input  wire logic [3:0]           startup_mode_setting,
  input  wire logic [2:0]           mode_select_setting,
  input  wire logic                 mode_lock_input,
  input  wire logic                 quiet,
  input  wire op_mode_pkg::op_mode_t current,
  input  wire op_mode_pkg::op_mode_t target,
  output op_mode_pkg::op_mode_t     powerup,
  output logic                      allowed
);
  logic net_first;
  logic net_direct;
  logic pn;
  logic tgt_ok;
  logic run_ok;

  always_comb begin
    net_first  = (startup_mode_setting == op_mode_pkg::SU_1) ||
                 (startup_mode_setting == op_mode_pkg::SU_2);
    net_direct = (startup_mode_setting == op_mode_pkg::SU_10) ||
                 (startup_mode_setting == op_mode_pkg::SU_12);
    pn = ((current == op_mode_pkg::panel_mode) && (target == op_mode_pkg::network_mode)) ||
         ((current == op_mode_pkg::network_mode) && (target == op_mode_pkg::panel_mode));
    tgt_ok = (target != current) && (target != op_mode_pkg::combined_mode);
    run_ok = quiet || (mode_select_setting == op_mode_pkg::MS_6);
    powerup = op_mode_pkg::terminal_mode;
    allowed = 1'b0;
    case (mode_select_setting)
      op_mode_pkg::MS_1: begin
        powerup = op_mode_pkg::panel_mode;
      end
      op_mode_pkg::MS_3, op_mode_pkg::MS_4: begin
        powerup = op_mode_pkg::combined_mode;
      end
      op_mode_pkg::MS_2: begin
        powerup = (net_first || net_direct) ? op_mode_pkg::network_mode
                                            : op_mode_pkg::terminal_mode;
        allowed = !net_direct && quiet && tgt_ok && (target != op_mode_pkg::panel_mode);
      end
      op_mode_pkg::MS_0, op_mode_pkg::MS_6: begin
        powerup = (net_first || net_direct) ? op_mode_pkg::network_mode
                                            : op_mode_pkg::terminal_mode;
        allowed = run_ok && tgt_ok && (net_direct ? pn : !pn);
      end
      op_mode_pkg::MS_7: begin
        powerup = (net_first && mode_lock_input) ? op_mode_pkg::network_mode
                                                 : op_mode_pkg::terminal_mode;
        allowed = mode_lock_input && quiet && tgt_ok && !pn;
      end
      default: begin
        powerup = op_mode_pkg::terminal_mode;
        allowed = 1'b0;
      end
    endcase
  end
endmodule // mode_policy

// File: op_mode_pkg.sv
// shared constants and types for the drive operation mode selector
// assumes a single 20 MHz clock domain and an AXI4-Lite register slave
package op_mode_pkg;

  // register byte offsets
  localparam logic [7:0] STARTUP_OFF  = 8'h00;
  localparam logic [7:0] MODE_SEL_OFF = 8'h04;
  localparam logic [7:0] COAST_OFF    = 8'h08;
  localparam logic [7:0] MODE_REQ_OFF = 8'h0c;
  localparam logic [7:0] STATUS_OFF   = 8'h10;

  // values after reset
  localparam logic [3:0]  STARTUP_RST  = 4'h0;
  localparam logic [2:0]  MODE_SEL_RST = 3'h0;
  localparam logic [13:0] COAST_RST    = 14'h270f;

  // restart coasting time value that disables automatic restart
  localparam logic [13:0] COAST_NO_RESTART = 14'h270f;

  // startup mode setting codes
  localparam logic [3:0] SU_0  = 4'h0;
  localparam logic [3:0] SU_1  = 4'h1;
  localparam logic [3:0] SU_2  = 4'h2;
  localparam logic [3:0] SU_10 = 4'ha;
  localparam logic [3:0] SU_12 = 4'hc;

  // mode select setting codes; 5 is not a legal setting
  localparam logic [2:0] MS_0 = 3'h0;
  localparam logic [2:0] MS_1 = 3'h1;
  localparam logic [2:0] MS_2 = 3'h2;
  localparam logic [2:0] MS_3 = 3'h3;
  localparam logic [2:0] MS_4 = 3'h4;
  localparam logic [2:0] MS_5 = 3'h5;
  localparam logic [2:0] MS_6 = 3'h6;
  localparam logic [2:0] MS_7 = 3'h7;

  // status register field positions
  localparam int ST_MODE_LSB    = 0;
  localparam int ST_LATCH_LSB   = 4;
  localparam int ST_REFUSED_BIT = 8;
  localparam int ST_CLEAR_BIT   = 9;
  localparam int ST_PWEN_BIT    = 10;
  localparam int ST_PEND_BIT    = 11;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    terminal_mode,
    panel_mode,
    network_mode,
    combined_mode
  } op_mode_t;

endpackage
